// File: src/ddrpt_pkg.sv
// Shared constants, types and helpers for the power-state and calibration sequencer
package ddrpt_pkg;

  // Clock of the sequencer
  localparam int CLK_PERIOD_NS = 20;

  // Round a least time in ns up to whole clock cycles, never below one
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Larger of two terms
  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // Refresh cycle times of the attached part (plain defaults, set per part)
  localparam int REFRESH_CYCLE_NS   = 350;
  localparam int REFRESH4_CYCLE_NS  = 160;

  // Times as printed, in their own units
  localparam int EXIT_MARGIN_NS     = 10;
  localparam int MOD_NS             = 15;
  localparam int CKE_NS             = 5;
  localparam int XP_NS              = 6;
  localparam int VALID_CLK_NS       = 10;
  localparam int MPX_LOW_HOLD_NS    = 12;

  // Cycle counts
  localparam int INITIAL_CALIBRATION_CYC = 1024;
  localparam int ZQ_LONG_CYC        = 512;
  localparam int ZQ_SHORT_CYC       = 128;
  localparam int DLL_LOCK_CYC       = 768;
  localparam int COMMAND_PASS_DISABLE_DELAY_CYC = 4;
  localparam int MOD_CYC            = imax(24, ns2cyc(MOD_NS));
  localparam int CKE_CYC            = imax(3, ns2cyc(CKE_NS));
  localparam int XP_CYC             = imax(4, ns2cyc(XP_NS));
  localparam int CK_ENTRY_CYC       = imax(5, ns2cyc(VALID_CLK_NS));
  localparam int CK_EXIT_CYC        = imax(5, ns2cyc(VALID_CLK_NS));
  localparam int XPR_CYC            = imax(5, ns2cyc(REFRESH_CYCLE_NS + EXIT_MARGIN_NS));
  localparam int SELF_REFRESH_EXIT_DELAY_CYC = ns2cyc(REFRESH_CYCLE_NS + EXIT_MARGIN_NS);
  localparam int XS_ABORT_CYC       = ns2cyc(REFRESH4_CYCLE_NS + EXIT_MARGIN_NS);
  localparam int XS_FAST_CYC        = ns2cyc(REFRESH4_CYCLE_NS + EXIT_MARGIN_NS);
  localparam int LOCKED_SELF_REFRESH_EXIT_DELAY_CYC = DLL_LOCK_CYC;
  localparam int SELF_REFRESH_MIN_LOW_TIME_CYC = CKE_CYC + 1;
  localparam int MAX_POWER_SAVING_MODE_DISABLE_CYC = MOD_CYC + COMMAND_PASS_DISABLE_DELAY_CYC;
  localparam int POWER_SAVE_EXIT_DELAY_CYC = SELF_REFRESH_EXIT_DELAY_CYC;
  localparam int POWER_SAVE_EXIT_DLL_CYC =
    POWER_SAVE_EXIT_DELAY_CYC + LOCKED_SELF_REFRESH_EXIT_DELAY_CYC;
  localparam int MPX_LOW_HOLD_CYC   = ns2cyc(MPX_LOW_HOLD_NS);
  localparam int MPX_HIGH_HOLD_CYC  = XP_CYC;

  // Countdown timers
  localparam int TW                 = 12;
  localparam int NT                 = 7;
  localparam int TI_ANY             = 0;  // Blocks every command
  localparam int TI_NODLL           = 1;  // Blocks commands without locked loop
  localparam int TI_DLL             = 2;  // Blocks commands needing locked loop
  localparam int TI_MOD             = 3;  // Blocks non mode-register commands
  localparam int TI_CKE             = 4;  // Least time of the present CKE level
  localparam int TI_CLK             = 5;  // Valid clock interval
  localparam int TI_FAST            = 6;  // Calibration and fast settings after exit

  typedef logic [TW-1:0] ddrpt_cnt_t;

  // Command requests
  typedef enum logic [3:0] {
    C_NOP, C_ZQ_LONG, C_ZQ_SHORT, C_MRS, C_MRS_FAST, C_NODLL, C_DLL,
    C_SELF_REFRESH_ENTRY, C_POWER_DOWN_ENTRY, C_MAX_POWER_SAVING_MODE_IN,
    C_SELF_REFRESH_EXIT, C_SELF_REFRESH_ABORT_EXIT, C_POWER_DOWN_EXIT,
    C_MPX_CS_LOW, C_MPX_CS_HIGH
  } ddrpt_cmd_t;

  // Low power kinds
  typedef enum logic [1:0] {LP_SR, LP_PD, LP_MP} ddrpt_lp_t;

  // Request from user logic
  typedef struct packed {
    ddrpt_cmd_t cmd;
  } ddrpt_req_t;

  // Memory-side pins
  typedef struct packed {
    logic       ck_en;
    logic       cke;
    logic       cs_n;
    ddrpt_cmd_t cmd;
  } ddrpt_pins_t;

endpackage : ddrpt_pkg

// File: src/ddrpt_seq.sv
// Host sequencer for calibration, reset exit, self refresh, power-down and power saving mode
module ddrpt_seq
  import ddrpt_pkg::*;
(
  // Clock and reset
  input  wire logic         CLK,
  input  wire logic         ARST_N,
  // Parity configuration
  input  wire logic         PAR_EN,
  input  wire logic [3:0]   PARITY_LATENCY,
  // Command request
  input  wire logic         REQ_VALID,
  input  wire ddrpt_req_t   REQ,
  output logic              REQ_ACK,
  output logic              INIT_DONE,
  // Memory pins
  output ddrpt_pins_t       DRAM
);

  // Sequencer states
  typedef enum logic [2:0] {
    ST_BOOT, ST_INIT_CLK, ST_INIT_ZQ, ST_IDLE, ST_LOWPWR, ST_WAKE, ST_MPX, ST_MPXH
  } ddrpt_state_t;

  logic         rst_s1_reg;       // Reset release stage one
  logic         rst_n;            // Released reset
  ddrpt_state_t state_reg;        // Current state
  ddrpt_state_t state_next;       // Next state
  ddrpt_pins_t  pins_reg;         // Pin drive
  ddrpt_pins_t  pins_next;        // Next pin drive
  logic         ack_reg;          // Request taken
  logic         ack_next;         // Next taken flag
  logic         init_reg;         // Startup finished
  logic         init_next;        // Next startup flag
  ddrpt_lp_t    lp_reg;           // Kind of low power state
  ddrpt_lp_t    lp_next;          // Next kind
  ddrpt_cmd_t   exit_reg;         // Exit chosen by user
  ddrpt_cmd_t   exit_next;        // Next exit
  logic [NT-1:0] ld;              // Timer loads
  ddrpt_cnt_t   lv [NT];          // Timer load values
  logic [NT-1:0] tdone;           // Timer expired
  ddrpt_cmd_t   rcmd;             // Requested command
  logic         is_mrs;           // Mode register class
  logic         is_fast;          // Allowed early after self refresh exit
  logic         gate_base;        // No global or mode-register wait
  logic         ok_nodll;         // Unlocked command may go
  logic         ok_fast;          // Calibration or fast setting may go
  logic         ok_dll;           // Locked command may go
  logic         ok_entry;         // Low power entry may go
  logic         ok_exit;          // Exit matches and may go
  logic         cmd_ok;           // Requested command allowed now
  logic         take;             // Request taken this cycle
  ddrpt_cnt_t   par_add;          // Parity latency when parity is on

  // Reset release through two flops
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // One countdown per command class; a single rank is served
  for (genvar i = 0; i < NT; i++) begin : g_tmr
    ddrpt_timer u_tmr (
      .clk      (CLK),
      .rst_n    (rst_n),
      .load     (ld[i]),
      .load_val (lv[i]),
      .done     (tdone[i])
    );
  end

  // Command class decode
  assign rcmd      = REQ.cmd;
  assign is_mrs    = (rcmd == C_MRS) || (rcmd == C_MRS_FAST) ||
                     (rcmd == C_MAX_POWER_SAVING_MODE_IN);
  assign is_fast   = (rcmd == C_ZQ_LONG) || (rcmd == C_ZQ_SHORT) || (rcmd == C_MRS_FAST);
  assign gate_base = tdone[TI_ANY] && (is_mrs || tdone[TI_MOD]);
  assign ok_nodll  = gate_base && tdone[TI_NODLL];
  assign ok_fast   = gate_base && (tdone[TI_NODLL] || tdone[TI_FAST]);
  assign ok_dll    = ok_nodll && tdone[TI_DLL];
  assign ok_entry  = ok_nodll && tdone[TI_CKE];
  assign par_add   = PAR_EN ? ddrpt_cnt_t'(PARITY_LATENCY) : '0;

  // Exit allowed once the low level and clock hold are over
  assign ok_exit = tdone[TI_CKE] && tdone[TI_CLK] && (
                   (lp_reg == LP_SR && (rcmd == C_SELF_REFRESH_EXIT ||
                                        rcmd == C_SELF_REFRESH_ABORT_EXIT)) ||
                   (lp_reg == LP_PD && rcmd == C_POWER_DOWN_EXIT) ||
                   (lp_reg == LP_MP && (rcmd == C_MPX_CS_LOW || rcmd == C_MPX_CS_HIGH)));

  // Permission for the requested command
  assign cmd_ok = (state_reg == ST_LOWPWR) ? ok_exit :
                  (state_reg != ST_IDLE) ? 1'b0 :
                  (rcmd == C_DLL) ? ok_dll :
                  is_fast ? ok_fast :
                  (rcmd == C_SELF_REFRESH_ENTRY || rcmd == C_POWER_DOWN_ENTRY ||
                   rcmd == C_MAX_POWER_SAVING_MODE_IN) ? ok_entry :
                  (rcmd == C_MRS || rcmd == C_NODLL) ? ok_nodll : 1'b0;
  assign take   = REQ_VALID && !ack_reg && cmd_ok;

  // Sequencer next state and timer loads
  always_comb begin
    state_next     = state_reg;
    pins_next      = pins_reg;
    pins_next.cs_n = 1'b1;
    pins_next.cmd  = C_NOP;
    ack_next       = 1'b0;
    init_next      = init_reg;
    lp_next        = lp_reg;
    exit_next      = exit_reg;
    ld             = '0;
    for (int i = 0; i < NT; i++) begin
      lv[i] = '0;
    end
    unique case (state_reg)
      ST_BOOT: begin
        // Clock on, CKE low, valid clock before reset exit
        pins_next.ck_en = 1'b1;
        pins_next.cke   = 1'b0;
        ld[TI_CLK]      = 1'b1;
        lv[TI_CLK]      = ddrpt_cnt_t'(CK_EXIT_CYC);
        state_next      = ST_INIT_CLK;
      end
      ST_INIT_CLK: begin
        if (tdone[TI_CLK] && tdone[TI_CKE]) begin
          pins_next.cke = 1'b1;
          ld[TI_CKE]    = 1'b1;
          lv[TI_CKE]    = ddrpt_cnt_t'(CKE_CYC);
          ld[TI_ANY]    = 1'b1;
          lv[TI_ANY]    = ddrpt_cnt_t'(XPR_CYC);
          state_next    = ST_INIT_ZQ;
        end
      end
      ST_INIT_ZQ: begin
        // Initial calibration, then everything waits for it
        if (tdone[TI_ANY]) begin
          pins_next.cs_n = 1'b0;
          pins_next.cmd  = C_ZQ_LONG;
          ld[TI_ANY]     = 1'b1;
          lv[TI_ANY]     = ddrpt_cnt_t'(INITIAL_CALIBRATION_CYC);
          init_next      = 1'b1;
          state_next     = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (take) begin
          ack_next       = 1'b1;
          pins_next.cmd  = rcmd;
          pins_next.cs_n = (rcmd == C_POWER_DOWN_ENTRY);
          unique case (rcmd)
            C_ZQ_LONG: begin
              ld[TI_ANY] = 1'b1;
              lv[TI_ANY] = ddrpt_cnt_t'(ZQ_LONG_CYC);
            end
            C_ZQ_SHORT: begin
              ld[TI_ANY] = 1'b1;
              lv[TI_ANY] = ddrpt_cnt_t'(ZQ_SHORT_CYC);
            end
            C_MRS, C_MRS_FAST: begin
              ld[TI_MOD] = 1'b1;
              lv[TI_MOD] = ddrpt_cnt_t'(MOD_CYC);
            end
            C_SELF_REFRESH_ENTRY: begin
              pins_next.cke = 1'b0;
              ld[TI_CKE]    = 1'b1;
              lv[TI_CKE]    = ddrpt_cnt_t'(SELF_REFRESH_MIN_LOW_TIME_CYC) + par_add;
              ld[TI_CLK]    = 1'b1;
              lv[TI_CLK]    = ddrpt_cnt_t'(CK_ENTRY_CYC) + par_add;
              lp_next       = LP_SR;
              state_next    = ST_LOWPWR;
            end
            C_POWER_DOWN_ENTRY: begin
              pins_next.cke = 1'b0;
              ld[TI_CKE]    = 1'b1;
              lv[TI_CKE]    = ddrpt_cnt_t'(CKE_CYC);
              ld[TI_CLK]    = 1'b1;
              lv[TI_CLK]    = ddrpt_cnt_t'(CK_ENTRY_CYC) + par_add;
              lp_next       = LP_PD;
              state_next    = ST_LOWPWR;
            end
            C_MAX_POWER_SAVING_MODE_IN: begin
              // Clock must outlast the device's path disable (update plus 4)
              ld[TI_CLK] = 1'b1;
              lv[TI_CLK] = ddrpt_cnt_t'(MAX_POWER_SAVING_MODE_DISABLE_CYC);
              lp_next    = LP_MP;
              state_next = ST_LOWPWR;
            end
            default: begin
              // Plain commands need no new wait
            end
          endcase
        end
      end
      ST_LOWPWR: begin
        // Stop the clock once the entry hold is over
        pins_next.ck_en = !tdone[TI_CLK];
        if (take) begin
          ack_next        = 1'b1;
          exit_next       = rcmd;
          pins_next.ck_en = 1'b1;
          ld[TI_CLK]      = 1'b1;
          lv[TI_CLK]      = ddrpt_cnt_t'(CK_EXIT_CYC);
          state_next      = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (tdone[TI_CLK]) begin
          ld[TI_CKE] = 1'b1;
          lv[TI_CKE] = ddrpt_cnt_t'(CKE_CYC);
          if (lp_reg == LP_MP) begin
            // Low CKE pulse with CS set up for the exit variant
            pins_next.cke  = 1'b0;
            pins_next.cs_n = (exit_reg == C_MPX_CS_HIGH);
            state_next     = ST_MPX;
          end else begin
            pins_next.cke = 1'b1;
            pins_next.cmd = exit_reg;
            state_next    = ST_IDLE;
            if (lp_reg == LP_PD) begin
              ld[TI_ANY] = 1'b1;
              lv[TI_ANY] = ddrpt_cnt_t'(XP_CYC);
            end else begin
              ld[TI_NODLL] = 1'b1;
              lv[TI_NODLL] = (exit_reg == C_SELF_REFRESH_ABORT_EXIT) ?
                             ddrpt_cnt_t'(XS_ABORT_CYC) :
                             ddrpt_cnt_t'(SELF_REFRESH_EXIT_DELAY_CYC);
              ld[TI_FAST]  = 1'b1;
              lv[TI_FAST]  = ddrpt_cnt_t'(XS_FAST_CYC);
              ld[TI_DLL]   = 1'b1;
              lv[TI_DLL]   = ddrpt_cnt_t'(LOCKED_SELF_REFRESH_EXIT_DELAY_CYC);
            end
          end
        end
      end
      ST_MPX: begin
        pins_next.cs_n = (exit_reg == C_MPX_CS_HIGH);
        if (tdone[TI_CKE]) begin
          pins_next.cke = 1'b1;
          pins_next.cmd = exit_reg;
          ld[TI_CKE]    = 1'b1;
          lv[TI_CKE]    = ddrpt_cnt_t'(CKE_CYC);
          ld[TI_ANY]    = 1'b1;
          lv[TI_ANY]    = (exit_reg == C_MPX_CS_LOW) ?
                          ddrpt_cnt_t'(MPX_LOW_HOLD_CYC) :
                          ddrpt_cnt_t'(MPX_HIGH_HOLD_CYC);
          ld[TI_NODLL]  = 1'b1;
          lv[TI_NODLL]  = ddrpt_cnt_t'(POWER_SAVE_EXIT_DELAY_CYC);
          ld[TI_DLL]    = 1'b1;
          lv[TI_DLL]    = ddrpt_cnt_t'(POWER_SAVE_EXIT_DLL_CYC);
          state_next    = ST_MPXH;
        end
      end
      ST_MPXH: begin
        // Hold CS at its exit level relative to the CKE rise
        pins_next.cs_n = (exit_reg == C_MPX_CS_HIGH) || tdone[TI_ANY];
        if (tdone[TI_ANY]) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  // State and pin registers
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_BOOT;
      pins_reg  <= '{ck_en: 1'b0, cke: 1'b0, cs_n: 1'b1, cmd: C_NOP};
      ack_reg   <= 1'b0;
      init_reg  <= 1'b0;
      lp_reg    <= LP_SR;
      exit_reg  <= C_NOP;
    end else begin
      state_reg <= state_next;
      pins_reg  <= pins_next;
      ack_reg   <= ack_next;
      init_reg  <= init_next;
      lp_reg    <= lp_next;
      exit_reg  <= exit_next;
    end
  end

  assign DRAM      = pins_reg;
  assign REQ_ACK   = ack_reg;
  assign INIT_DONE = init_reg;

  // Helper counters watched by the assertions
  ddrpt_cnt_t since_cmd_reg;   // Cycles since the last command on the pins
  ddrpt_cmd_t last_cmd_reg;    // Last command on the pins
  ddrpt_cnt_t since_rise_reg;  // Cycles since CKE rose
  ddrpt_cnt_t ck_run_reg;      // Cycles the clock has been running
  logic       cmd_vis;         // A command with CS low on the pins
  assign cmd_vis = !pins_reg.cs_n && pins_reg.cke && pins_reg.cmd != C_NOP;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      since_cmd_reg  <= '1;
      last_cmd_reg   <= C_NOP;
      since_rise_reg <= '1;
      ck_run_reg     <= '0;
    end else begin
      since_cmd_reg  <= cmd_vis ? ddrpt_cnt_t'(1) :
                        (since_cmd_reg == '1) ? since_cmd_reg : since_cmd_reg + ddrpt_cnt_t'(1);
      last_cmd_reg   <= cmd_vis ? pins_reg.cmd : last_cmd_reg;
      since_rise_reg <= (pins_next.cke && !pins_reg.cke) ? '0 :
                        (since_rise_reg == '1) ? since_rise_reg : since_rise_reg + ddrpt_cnt_t'(1);
      ck_run_reg     <= !pins_reg.ck_en ? '0 :
                        (ck_run_reg == '1) ? ck_run_reg : ck_run_reg + ddrpt_cnt_t'(1);
    end
  end

  a_zq_long_gap: assert property (@(posedge CLK) disable iff (!rst_n)
    cmd_vis && last_cmd_reg == C_ZQ_LONG |-> since_cmd_reg >= ddrpt_cnt_t'(ZQ_LONG_CYC))
    else $error("command too soon after long calibration");
  a_zq_short_gap: assert property (@(posedge CLK) disable iff (!rst_n)
    cmd_vis && last_cmd_reg == C_ZQ_SHORT |-> since_cmd_reg >= ddrpt_cnt_t'(ZQ_SHORT_CYC))
    else $error("command too soon after short calibration");
  a_mod_update_wait: assert property (@(posedge CLK) disable iff (!rst_n)
    cmd_vis && last_cmd_reg == C_MRS && !(pins_reg.cmd inside {C_MRS, C_MRS_FAST})
    |-> since_cmd_reg >= ddrpt_cnt_t'(MOD_CYC))
    else $error("command before mode register update delay");
  a_cke_low_hold: assert property (@(posedge CLK) disable iff (!rst_n)
    $fell(pins_reg.cke) |-> !pins_reg.cke [*3])
    else $error("CKE low level too short");
  a_clk_after_entry: assert property (@(posedge CLK) disable iff (!rst_n)
    $fell(pins_reg.cke) |-> pins_reg.ck_en [*5])
    else $error("clock stopped too soon after entry");
  a_clk_before_exit: assert property (@(posedge CLK) disable iff (!rst_n)
    $rose(pins_reg.cke) |-> ck_run_reg >= ddrpt_cnt_t'(CK_EXIT_CYC))
    else $error("clock not valid long enough before exit");
  a_exit_cmd_wait: assert property (@(posedge CLK) disable iff (!rst_n)
    cmd_vis && !$rose(pins_reg.cke) |-> since_rise_reg >= ddrpt_cnt_t'(XP_CYC))
    else $error("command too soon after CKE rise");
  a_dll_lock_wait: assert property (@(posedge CLK) disable iff (!rst_n)
    cmd_vis && pins_reg.cmd == C_DLL && lp_reg == LP_SR
    |-> since_rise_reg >= ddrpt_cnt_t'(DLL_LOCK_CYC))
    else $error("locked command before loop lock time");
  a_ack_single_pulse: assert property (@(posedge CLK) disable iff (!rst_n)
    REQ_ACK |=> !REQ_ACK)
    else $error("acknowledge longer than one cycle");

  c_self_refresh: cover property (@(posedge CLK) disable iff (!rst_n)
    pins_reg.cmd == C_SELF_REFRESH_EXIT && pins_reg.cke);
  c_power_down: cover property (@(posedge CLK) disable iff (!rst_n)
    pins_reg.cmd == C_POWER_DOWN_EXIT);
  c_power_save_exit: cover property (@(posedge CLK) disable iff (!rst_n)
    $rose(pins_reg.cke) && !pins_reg.cs_n);
  c_zq_short: cover property (@(posedge CLK) disable iff (!rst_n)
    cmd_vis && pins_reg.cmd == C_ZQ_SHORT);

endmodule // ddrpt_seq

// File: src/ddrpt_timer.sv
// Countdown that only lengthens, with a registered expiry flag
module ddrpt_timer
  import ddrpt_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Load
  input  wire logic       load,
  input  wire ddrpt_cnt_t load_val,
  // Status
  output logic            done
);

  ddrpt_cnt_t cnt_reg;   // Cycles left
  ddrpt_cnt_t cnt_next;  // Next count
  logic       done_reg;  // Count at zero

  // Keep the larger of the running and the new wait
  assign cnt_next = (load && load_val > cnt_reg) ? load_val :
                    (cnt_reg != '0) ? cnt_reg - ddrpt_cnt_t'(1) : cnt_reg;
  assign done     = done_reg;

  // Count register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= '0;
      done_reg <= 1'b1;
    end else begin
      cnt_reg  <= cnt_next;
      done_reg <= (cnt_next == '0);
    end
  end

endmodule // ddrpt_timer

// File: test/ddr4_power_state_zq_timing_tb_top.sv
// Testbench for the power-state and calibration sequencer
module ddr4_power_state_zq_timing_tb_top;
  import ddrpt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PAR_LAT = 2;  // Parity latency used in the run
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        req_valid = 1'b0;
  ddrpt_req_t  req = '{cmd: C_NOP};
  logic        req_ack;
  logic        init_done;
  ddrpt_pins_t dram;
  int          dev_errs;
  logic        path_on;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          t0, t1, n;
  always #10 clk = ~clk;
  // Edge counter for measuring gaps
  always @(posedge clk) cyc <= cyc + 1;
  ddrpt_seq i_dut (.CLK(clk), .ARST_N(arst_n), .PAR_EN(1'b1), .PARITY_LATENCY(4'h2),
    .REQ_VALID(req_valid), .REQ(req), .REQ_ACK(req_ack), .INIT_DONE(init_done), .DRAM(dram));
  ddrpt_dev_model i_dev (.clk(clk), .pins(dram), .errs(dev_errs), .path_on(path_on));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      fail_count++;
    end
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hold a request until acknowledged, return the ack cycle
  task automatic issue(input ddrpt_cmd_t c, output int t);
    int k;
    k = 0;
    @(negedge clk);
    req_valid = 1'b1;
    req.cmd = c;
    while (req_ack !== 1'b1 && k < 3000) begin k++; @(negedge clk); end
    if (k >= 3000) fail_count++;
    t = cyc;
    req_valid = 1'b0;
  endtask
  // Cycles until the named pin reaches a level
  task automatic wait_pin(input logic ck, input logic v, output int k);
    k = 0;
    while ((ck ? dram.ck_en : dram.cke) !== v && k < 2000) begin k++; @(negedge clk); end
    if (k >= 2000) fail_count++;
  endtask
  // Calibration spacing after boot and in normal operation
  task automatic test_zq();
    issue(C_ZQ_SHORT, t1);
    chk(t1 - t0 >= INITIAL_CALIBRATION_CYC, 1'b1);
    t0 = t1;
    issue(C_ZQ_LONG, t1);
    chk(t1 - t0 > ZQ_SHORT_CYC, 1'b1);
    t0 = t1;
    issue(C_NODLL, t1);
    chk(t1 - t0 > ZQ_LONG_CYC, 1'b1);
    issue(C_MRS, t0);
    issue(C_NODLL, t1);
    chk(t1 - t0 >= MOD_CYC, 1'b1);
  endtask
  // Self refresh entry and exit with parity on
  task automatic test_self_refresh();
    issue(C_SELF_REFRESH_ENTRY, t0);
    chk(dram.cke, 1'b0);
    wait_pin(1'b1, 1'b0, n);
    chk(n >= CK_ENTRY_CYC + PAR_LAT, 1'b1);
    issue(C_SELF_REFRESH_EXIT, t1);
    wait_pin(1'b0, 1'b1, n);
    chk(n >= CK_EXIT_CYC, 1'b1);
    chk(cyc - t0 >= SELF_REFRESH_MIN_LOW_TIME_CYC + PAR_LAT, 1'b1);
    t0 = cyc;
    issue(C_NODLL, t1);
    chk(t1 - t0 >= SELF_REFRESH_EXIT_DELAY_CYC, 1'b1);
    issue(C_DLL, t1);
    chk(t1 - t0 >= LOCKED_SELF_REFRESH_EXIT_DELAY_CYC, 1'b1);
  endtask
  // Maximum power saving entry and exit with chip select high
  task automatic test_power_save();
    issue(C_MAX_POWER_SAVING_MODE_IN, t0);
    wait_pin(1'b1, 1'b0, n);
    chk(n >= MAX_POWER_SAVING_MODE_DISABLE_CYC, 1'b1);
    chk(path_on, 1'b0);
    issue(C_MPX_CS_HIGH, t1);
    wait_pin(1'b0, 1'b0, n);
    chk(n >= CK_EXIT_CYC, 1'b1);
    wait_pin(1'b0, 1'b1, n);
    t0 = cyc;
    issue(C_NODLL, t1);
    chk(t1 - t0 >= POWER_SAVE_EXIT_DELAY_CYC, 1'b1);
    issue(C_DLL, t1);
    chk(t1 - t0 >= POWER_SAVE_EXIT_DLL_CYC, 1'b1);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    n = 0;
    while (init_done !== 1'b1 && n < 2000) begin n++; @(negedge clk); end
    if (n >= 2000) fail_count++;
    t0 = cyc;
    chk(dram.cke, 1'b1);
    test_zq();
    test_self_refresh();
    test_power_save();
    chk(dev_errs, 0);
    report_and_stop();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
endmodule // ddr4_power_state_zq_timing_tb_top

// File: test/ddrpt_dev_model.sv
// Behavioural memory device that watches command spacing on the pins
module ddrpt_dev_model
  import ddrpt_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Memory pins
  input  wire ddrpt_pins_t pins,
  // Status
  output int               errs,
  output logic             path_on
);
  timeunit 1ns;
  timeprecision 1ps;
  int   gap  = 0;     // Cycles since last command
  int   need = 0;     // Least gap the last command asks
  int   dis  = 0;     // Countdown to command path off
  logic boot = 1'b1;  // First calibration is the initial one
  initial errs = 0;
  initial path_on = 1'b1;
  // Count gaps and flag commands that come too early
  always @(posedge clk) begin
    gap <= gap + 1;
    if (dis == 1) path_on <= 1'b0;
    if (dis > 0) dis <= dis - 1;
    if (pins.ck_en && !pins.cs_n && pins.cmd != C_NOP) begin
      if (gap < need) errs <= errs + 1;
      gap  <= 1;
      boot <= 1'b0;
      need <= (pins.cmd == C_ZQ_SHORT) ? ZQ_SHORT_CYC :
              (pins.cmd != C_ZQ_LONG) ? 0 : boot ? INITIAL_CALIBRATION_CYC : ZQ_LONG_CYC;
      if (pins.cmd == C_MAX_POWER_SAVING_MODE_IN) dis <= MAX_POWER_SAVING_MODE_DISABLE_CYC;
    end
  end
endmodule // ddrpt_dev_model
